// ===== hw/erf_evt_cnt.v
`timescale 1ns/1ps
// saturating event counter
module erf_evt_cnt #(
  parameter W = 16
) (
  input  wire         ref_clk,  // clock
  input  wire         rst,      // synchronous reset
  input  wire         inc,      // count one event
  output reg  [W-1:0] count     // events seen
);
  always @(posedge ref_clk) begin
    if (rst) begin
      count <= {W{1'b0}};
    end else if (inc && (count != {W{1'b1}})) begin
      count <= count + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ===== hw/erf_ram.v
`timescale 1ns/1ps
// simple dual-port word store, one write and one registered read port
module erf_ram (
  input  wire        ref_clk,  // clock
  input  wire        wr_en,    // write strobe
  input  wire [11:0] wr_addr,  // write word address
  input  wire [31:0] wr_data,  // write data
  input  wire [11:0] rd_addr,  // read word address
  output reg  [31:0] rd_data   // data one cycle after rd_addr
);
  reg [31:0] mem [0:3071];

  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ===== hw/erf_regs.vh
`ifndef ERF_REGS_VH
`define ERF_REGS_VH

// buffer geometry: 12 KB held as 32-bit words
`define ERF_DEPTH          13'd3072
`define ERF_DEPTH_M1       12'd3071
`define ERF_AW             12
`define ERF_CMD_WORDS      12'd2
`define ERF_SOF_NEED       12'd3068

// register byte offsets
`define ERF_CTL_ADDR       8'h00
`define ERF_OVF_CNT_ADDR   8'h04
`define ERF_FRAMES_ADDR    8'h08

// receive_buffer_control_register fields
`define ERF_CTL_KEEP_BAD   0
`define ERF_CTL_STRIP_FCS  1
`define ERF_CTL_RAW_L3_CHECKSUM_FIELD_EN    2
`define ERF_CTL_OVF        3
`define ERF_CTL_USED_LSB   16
`define ERF_CTL_RESET      3'h0

// status word A fields
`define ERF_A_IPCSUM       31
`define ERF_A_L4CSUM       30
`define ERF_A_IPVER        29
`define ERF_A_PROTO_MSB    28
`define ERF_A_PROTO_LSB    27
`define ERF_A_EXACT        26
`define ERF_A_BCAST        25
`define ERF_FCS_BYTES      14'h0004

// status word B fields
`define ERF_B_RAW_L3_CHECKSUM_FIELD_LSB     16
`define ERF_B_VLAN_LSB     0

`define ERF_CNT_W          16

`endif

// ===== hw/erf_rx_fifo.v
// Summary of operation
// [RULE_01] a 12 KB word buffer sits between filter engine and bulk-in transmitter
// [RULE_02] write head sits two words before frame data, kept for status words A and B
// [RULE_03] first data word carries status word C plus first two frame bytes
// [RULE_04] read head jumps to next frame start once a frame is fully read
// [RULE_05] write pointer advances per stored word; status words are written last
// [RULE_06] a frame is visible to the reader only after its status words land
// [RULE_07] bad or filtered frames are rewound away unless keep-bad is set
// [RULE_08] stored data amount goes to reader and to the control register
// [RULE_09] reader sees a flag while at least one complete frame is stored
// [RULE_10] overflow raises the overflow interrupt and sets the overflow status bit
// [RULE_11] checksum-only faults never cause a drop
// [RULE_12] a frame that fills the buffer is dropped whatever keep-bad says
// [RULE_13] every overflow bumps an overflow counter; the 16-bit counter here saturates at 65535 and then holds
// [RULE_14] write rewind loads write pointer from write head; read likewise
// [RULE_15] after an overflow drop the rest of the frame is ignored until next start
// [RULE_16] reader may rewind its pointer to the frame start for a resend
// [RULE_17] status word B holds raw L3 checksum when enabled and the VLAN tag
// [RULE_18] word A bit 31 flags an IP header checksum error
// [RULE_19] word A bit 30 flags a TCP, UDP, ICMP or IGMP checksum error
// [RULE_20] word A bit 29 is one for IPv6, zero for IPv4
// [RULE_21] word A bits 28:27 give the protocol code
// [RULE_22] word A bit 26 flags an exact-match address pass
// [RULE_23] word A bit 25 flags the broadcast destination
// [RULE_24] word A bits 13:0 hold frame length, minus four when stripping
// [RULE_25] word B: checksum in 31:16, VLAN tag in 15:0
// [RULE_26] full when the next write would reach the read head
// [RULE_27] pointers wrap at buffer depth; heads move only at boundaries or rewinds
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "erf_regs.vh"
module erf_rx_fifo (
  input  wire        ref_clk,            // 125 MHz clock
  input  wire        rst,                // synchronous reset, active high
  input  wire        wb_cyc_i,           // wishbone cycle
  input  wire        wb_stb_i,           // wishbone strobe
  input  wire        wb_we_i,            // wishbone write enable
  input  wire [7:0]  wb_adr_i,           // wishbone byte address
  input  wire [3:0]  wb_sel_i,           // wishbone byte selects
  input  wire [31:0] wb_dat_i,           // wishbone write data
  output reg  [31:0] wb_dat_o,           // wishbone read data
  output reg         wb_ack_o,           // wishbone acknowledge
  input  wire        flt_sof,            // frame start pulse from filter engine
  input  wire        flt_valid,          // data word valid
  input  wire [31:0] flt_data,           // data word; first word holds word C
  input  wire        flt_eof,            // frame end pulse, status below valid
  input  wire [13:0] flt_frame_length,   // received length in bytes
  input  wire        flt_ip_raw_l3_checksum_field_err,    // IP header checksum error
  input  wire        flt_l4_raw_l3_checksum_field_err,    // TCP/UDP/ICMP/IGMP checksum error
  input  wire        flt_ipv6,           // frame carries IPv6
  input  wire [1:0]  flt_proto,          // protocol code
  input  wire        flt_exact_pass,     // exact-match filter passed
  input  wire        flt_bcast,          // broadcast destination
  input  wire        flt_rx_err,         // receive error of any kind
  input  wire        flt_filtered,       // frame failed the address filter
  input  wire [15:0] flt_raw_raw_l3_checksum_field,       // raw layer-3 checksum
  input  wire [15:0] flt_vlan_tag,       // extracted VLAN tag
  output reg         flt_busy,           // status words being written
  output reg  [31:0] bulk_data,          // word to bulk-in transmitter
  output reg         bulk_valid,         // bulk_data valid
  input  wire        bulk_ready,         // transmitter takes word
  input  wire        bulk_done,          // frame fully read, pulse
  input  wire        bulk_rewind,        // resend frame from its start, pulse
  output reg         bulk_frame_avail,   // at least one whole frame stored
  output reg  [11:0] bulk_used_words,    // committed words not yet read
  output reg         overflow_irq        // buffer overflow interrupt level
);
  localparam [1:0] WS_IDLE = 2'd0;
  localparam [1:0] WS_DATA = 2'd1;
  localparam [1:0] WS_CMDA = 2'd2;
  localparam [1:0] WS_CMDB = 2'd3;

  function [11:0] ptr_add;
    input [11:0] p;
    input [11:0] n;
    reg   [12:0] s;
    begin
      s = {1'b0, p} + {1'b0, n};
      if (s >= `ERF_DEPTH) begin // [RULE_27]
        s = s - `ERF_DEPTH;
      end
      ptr_add = s[11:0];
    end
  endfunction

  function [11:0] ptr_diff;
    input [11:0] a;
    input [11:0] b;
    reg   [12:0] d;
    begin
      if (a >= b) begin
        d = {1'b0, a} - {1'b0, b};
      end else begin
        d = {1'b0, a} + `ERF_DEPTH - {1'b0, b}; // [RULE_27]
      end
      ptr_diff = d[11:0];
    end
  endfunction

  reg  [1:0]  wstate_reg;
  reg  [11:0] wr_ptr_reg;
  reg  [11:0] wr_head_reg;
  reg  [11:0] rd_ptr_reg;
  reg  [11:0] rd_head_reg;
  reg         discard_reg;
  reg  [31:0] cmd_a_reg;
  reg  [31:0] cmd_b_reg;
  reg  [11:0] frames_reg;
  reg         keep_bad_reg;
  reg         strip_fcs_reg;
  reg         raw_l3_checksum_field_en_reg;
  reg         ovf_flag_reg;
  reg         rd_pend_reg;
  reg         ram_we;
  reg  [11:0] ram_waddr;
  reg  [31:0] ram_wdata;
  reg         ovf_evt;
  wire [31:0] ram_q;
  wire [15:0] ovf_count;
  wire [11:0] wr_fill   = ptr_diff(wr_ptr_reg, rd_head_reg);
  wire [11:0] head_fill = ptr_diff(wr_head_reg, rd_head_reg);
  wire        full_now  = (wr_fill == `ERF_DEPTH_M1); // [RULE_26]
  wire        bad_frame = flt_rx_err | flt_filtered; // [RULE_11]
  wire [13:0] len_adj   = strip_fcs_reg ? (flt_frame_length - `ERF_FCS_BYTES)
                                        : flt_frame_length; // [RULE_24]
  wire        commit_end = (wstate_reg == WS_CMDB);
  wire        rd_issue  = !rd_pend_reg && !bulk_valid && (rd_ptr_reg != wr_head_reg) &&
                          !bulk_done && !bulk_rewind; // [RULE_06]
  wire        wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  erf_ram u_ram (
    .ref_clk (ref_clk),
    .wr_en   (ram_we),
    .wr_addr (ram_waddr),
    .wr_data (ram_wdata),
    .rd_addr (rd_ptr_reg),
    .rd_data (ram_q)
  ); // [RULE_01]

  erf_evt_cnt #(.W(`ERF_CNT_W)) u_ovf_cnt (
    .ref_clk (ref_clk),
    .rst     (rst),
    .inc     (ovf_evt),
    .count   (ovf_count)
  ); // [RULE_13]

  // write side: data words land at wr_ptr, status words at the head slot
  always @(posedge ref_clk) begin
    if (rst) begin
      wstate_reg  <= WS_IDLE;
      wr_ptr_reg  <= 12'h000;
      wr_head_reg <= 12'h000;
      discard_reg <= 1'b0;
      cmd_a_reg   <= 32'h00000000;
      cmd_b_reg   <= 32'h00000000;
      ram_we      <= 1'b0;
      ram_waddr   <= 12'h000;
      ram_wdata   <= 32'h00000000;
      ovf_evt     <= 1'b0;
      flt_busy    <= 1'b0;
    end else begin
      ram_we  <= 1'b0;
      ovf_evt <= 1'b0;
      case (wstate_reg)
        WS_IDLE, WS_DATA: begin
          if (flt_sof) begin
            // a new frame always restarts from the head, dropping any unfinished one
            if (head_fill > `ERF_SOF_NEED) begin
              wr_ptr_reg  <= wr_head_reg; // [RULE_14]
              discard_reg <= 1'b1; // [RULE_12]
              ovf_evt     <= 1'b1; // [RULE_10]
              wstate_reg  <= WS_IDLE;
            end else begin
              wr_ptr_reg  <= ptr_add(wr_head_reg, `ERF_CMD_WORDS); // [RULE_02]
              discard_reg <= 1'b0; // [RULE_15]
              wstate_reg  <= WS_DATA;
            end
          end else if (wstate_reg == WS_DATA && !discard_reg) begin
            if (flt_valid && full_now) begin
              wr_ptr_reg  <= wr_head_reg; // [RULE_14]
              discard_reg <= 1'b1; // [RULE_15]
              ovf_evt     <= 1'b1; // [RULE_10]
              wstate_reg  <= WS_IDLE; // [RULE_12]
            end else begin
              if (flt_valid) begin
                ram_we     <= 1'b1;
                ram_waddr  <= wr_ptr_reg; // [RULE_03]
                ram_wdata  <= flt_data;
                wr_ptr_reg <= ptr_add(wr_ptr_reg, 12'h001); // [RULE_05]
              end
              if (flt_eof) begin
                if (bad_frame && !keep_bad_reg) begin
                  wr_ptr_reg <= wr_head_reg; // [RULE_07]
                  wstate_reg <= WS_IDLE;
                end else begin
                  cmd_a_reg <= {flt_ip_raw_l3_checksum_field_err, flt_l4_raw_l3_checksum_field_err, flt_ipv6, flt_proto, // [RULE_18] [RULE_19] [RULE_20]
                                flt_exact_pass, flt_bcast, 11'h000, len_adj}; // [RULE_21] [RULE_22] [RULE_23]
                  cmd_b_reg <= {(raw_l3_checksum_field_en_reg ? flt_raw_raw_l3_checksum_field : 16'h0000), // [RULE_25]
                                flt_vlan_tag}; // [RULE_17]
                  flt_busy  <= 1'b1;
                  wstate_reg <= WS_CMDA;
                end
              end
            end
          end else if (flt_eof) begin
            wstate_reg <= WS_IDLE; // [RULE_15]
          end
        end
        WS_CMDA: begin
          ram_we     <= 1'b1;
          ram_waddr  <= wr_head_reg;
          ram_wdata  <= cmd_a_reg; // [RULE_05]
          wstate_reg <= WS_CMDB;
        end
        WS_CMDB: begin
          ram_we      <= 1'b1;
          ram_waddr   <= ptr_add(wr_head_reg, 12'h001);
          ram_wdata   <= cmd_b_reg;
          wr_head_reg <= wr_ptr_reg; // [RULE_27]
          flt_busy    <= 1'b0;
          wstate_reg  <= WS_IDLE;
        end
        default: begin
          wstate_reg <= WS_IDLE;
        end
      endcase
    end
  end

  // the head moves on the edge that issues the last status write, before the ram stores it;
  // word A is already in the ram, so the reader can never fetch a status word before it is there
  always @(posedge ref_clk) begin
    if (rst) begin
      frames_reg <= 12'h000;
    end else if (commit_end && !bulk_done) begin
      frames_reg <= frames_reg + 12'h001;
    end else if (!commit_end && bulk_done && frames_reg != 12'h000) begin
      frames_reg <= frames_reg - 12'h001;
    end
  end

  // read side: one word in flight; throughput traded for simple timing
  always @(posedge ref_clk) begin
    if (rst) begin
      rd_ptr_reg  <= 12'h000;
      rd_head_reg <= 12'h000;
      rd_pend_reg <= 1'b0;
      bulk_valid  <= 1'b0;
      bulk_data   <= 32'h00000000;
    end else if (bulk_rewind) begin
      rd_ptr_reg  <= rd_head_reg; // [RULE_16]
      rd_pend_reg <= 1'b0;
      bulk_valid  <= 1'b0;
    end else if (bulk_done) begin
      rd_head_reg <= rd_ptr_reg; // [RULE_04]
      rd_pend_reg <= 1'b0;
      bulk_valid  <= 1'b0;
    end else begin
      rd_pend_reg <= rd_issue;
      if (rd_pend_reg) begin
        bulk_data  <= ram_q;
        bulk_valid <= 1'b1;
        rd_ptr_reg <= ptr_add(rd_ptr_reg, 12'h001); // [RULE_27]
      end else if (bulk_valid && bulk_ready) begin
        bulk_valid <= 1'b0;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      bulk_frame_avail <= 1'b0;
      bulk_used_words  <= 12'h000;
      overflow_irq     <= 1'b0;
    end else begin
      bulk_frame_avail <= (frames_reg != 12'h000); // [RULE_09]
      bulk_used_words  <= ptr_diff(wr_head_reg, rd_ptr_reg); // [RULE_08]
      overflow_irq     <= ovf_flag_reg; // [RULE_10]
    end
  end

  // control register and wishbone slave; one wait state per access
  always @(posedge ref_clk) begin
    if (rst) begin
      keep_bad_reg  <= 1'b0;
      strip_fcs_reg <= 1'b0;
      raw_l3_checksum_field_en_reg   <= 1'b0;
      ovf_flag_reg  <= 1'b0;
      wb_ack_o      <= 1'b0;
      wb_dat_o      <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (ovf_evt) begin
        ovf_flag_reg <= 1'b1; // [RULE_10]
      end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `ERF_CTL_ADDR &&
                   wb_dat_i[`ERF_CTL_OVF]) begin
        ovf_flag_reg <= 1'b0;
      end
      if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `ERF_CTL_ADDR) begin
        keep_bad_reg  <= wb_dat_i[`ERF_CTL_KEEP_BAD]; // [RULE_07]
        strip_fcs_reg <= wb_dat_i[`ERF_CTL_STRIP_FCS];
        raw_l3_checksum_field_en_reg   <= wb_dat_i[`ERF_CTL_RAW_L3_CHECKSUM_FIELD_EN];
      end
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `ERF_CTL_ADDR: begin
            wb_dat_o <= {4'h0, ptr_diff(wr_head_reg, rd_ptr_reg),
                         12'h000, ovf_flag_reg, raw_l3_checksum_field_en_reg, strip_fcs_reg,
                         keep_bad_reg}; // [RULE_08]
          end
          `ERF_OVF_CNT_ADDR: begin
            wb_dat_o <= {16'h0000, ovf_count};
          end
          `ERF_FRAMES_ADDR: begin
            wb_dat_o <= {20'h00000, frames_reg};
          end
          default: begin
            wb_dat_o <= 32'h00000000;
          end
        endcase
      end
    end
  end
endmodule

// ===== testbench/erf_bulk_model.sv
`timescale 1ns/1ps
module erf_bulk_model (
  input  wire         ref_clk,             // clock
  input  wire         rst,                 // reset
  input  wire  [31:0] bulk_data,           // offered word
  input  wire         bulk_valid,          // word offered
  output logic        bulk_ready = 1'h0,   // word taken
  output logic        bulk_done = 1'h0,    // frame read
  output logic        bulk_rewind = 1'h0,  // resend request
  input  wire         rd_hold,             // stall reader
  input  wire         rd_rewind_req        // rewind one frame
);
  logic [31:0] cur[$];
  logic [31:0] got[$];
  int          tot;
  logic        used_rw = 1'h0;
  logic        dn;
  logic        rw;
  // words reach got only at frame end, so a rewind never leaks partial frames
  always @(posedge ref_clk) begin
    if (rst) begin
      bulk_ready <= 1'h0;
      bulk_done <= 1'h0;
      bulk_rewind <= 1'h0;
      used_rw <= 1'h0;
      cur.delete();
    end else begin
      dn = 1'h0;
      rw = 1'h0;
      if (bulk_valid && bulk_ready) begin
        cur.push_back(bulk_data);
        if (cur.size() == 1) tot = 2 + (bulk_data[13:0] + 5) / 4;
        if (rd_rewind_req && !used_rw && cur.size() == 2) begin
          rw = 1'h1;
          cur.delete();
        end else if (cur.size() == tot) begin
          dn = 1'h1;
          foreach (cur[i]) got.push_back(cur[i]);
          cur.delete();
        end
      end
      bulk_ready <= !rd_hold && ($urandom % 4 != 0);
      bulk_done <= dn;
      bulk_rewind <= rw;
      used_rw <= rd_rewind_req && (used_rw || rw);
    end
  end
endmodule

// ===== testbench/erf_rx_fifo_properties.sv
`timescale 1ns/1ps
module erf_rx_fifo_properties (
  input wire        ref_clk,          // clock
  input wire        rst,              // reset
  input wire        wb_cyc_i,         // cycle
  input wire        wb_stb_i,         // strobe
  input wire        wb_we_i,          // write
  input wire [31:0] wb_dat_o,         // read data
  input wire        wb_ack_o,         // ack
  input wire        flt_sof,          // frame start
  input wire        flt_valid,        // data word
  input wire        flt_eof,          // frame end
  input wire        flt_busy,         // status writes
  input wire [31:0] bulk_data,        // read word
  input wire        bulk_valid,       // word offered
  input wire        bulk_ready,       // word taken
  input wire        bulk_done,        // frame read
  input wire        bulk_rewind,      // resend
  input wire        bulk_frame_avail, // frame stored
  input wire [11:0] bulk_used_words,  // used words
  input wire        overflow_irq      // overflow
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire wb_req = wb_cyc_i && wb_stb_i;
  AST_ACK_NEXT: assert property (wb_req && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  AST_BUSY_TWO: assert property ($rose(flt_busy) |-> $past(flt_eof) ##1 flt_busy ##1 !flt_busy)
    else $error("status write window wrong");
  AST_AVAIL_COMMIT: assert property ($rose(bulk_frame_avail) |-> $past(flt_busy, 3))
    else $error("frame visible before commit");
  AST_VALID_HOLD: assert property (bulk_valid && !bulk_ready && !bulk_done && !bulk_rewind
    |=> bulk_valid && $stable(bulk_data))
    else $error("offered word not held");
  AST_VALID_FRAME: assert property ($rose(bulk_valid) |-> ##[0:3] bulk_frame_avail)
    else $error("word offered with no stored frame");
  AST_OVF_STICKY: assert property (overflow_irq && !(wb_req && wb_we_i) |=> overflow_irq)
    else $error("overflow flag lost");
  AST_OVF_CAUSE: assert property ($rose(overflow_irq)
    |-> $past(flt_sof || flt_valid, 2) || $past(flt_sof || flt_valid, 3))
    else $error("overflow without write traffic");
  AST_RESET_CLEAR: assert property ($past(rst) |-> !bulk_valid && !flt_busy && !overflow_irq
    && bulk_used_words == 12'h000)
    else $error("outputs not clear after reset");
  COV_COMMIT: cover property ($rose(flt_busy));
  COV_DONE: cover property (bulk_done);
  COV_REWIND: cover property (bulk_rewind);
  COV_OVF: cover property ($rose(overflow_irq));
endmodule
bind erf_rx_fifo erf_rx_fifo_properties u_props (.*);

// ===== testbench/erf_rx_fifo_tb.sv
`timescale 1ns/1ps
`include "erf_regs.vh"
module erf_rx_fifo_tb;
  logic        ref_clk = 1'h0, rst = 1'h1;
  logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, flt_data = 32'h0, wb_dat_o, bulk_data, rv, exp_q[$];
  logic        wb_ack_o, flt_busy, bulk_valid, bulk_ready, bulk_done, bulk_rewind;
  logic        bulk_frame_avail, overflow_irq, rd_hold = 1'h0, rd_rewind_req = 1'h0;
  logic [11:0] bulk_used_words;
  logic        flt_sof = 1'h0, flt_valid = 1'h0, flt_eof = 1'h0, flt_ip_raw_l3_checksum_field_err = 1'h0;
  logic        flt_l4_raw_l3_checksum_field_err = 1'h0, flt_ipv6 = 1'h0, flt_exact_pass = 1'h0;
  logic        flt_bcast = 1'h0, flt_rx_err = 1'h0, flt_filtered = 1'h0;
  logic [1:0]  flt_proto = 2'h0;
  logic [13:0] flt_frame_length = 14'h0;
  logic [15:0] flt_raw_raw_l3_checksum_field = 16'h0, flt_vlan_tag = 16'h0;
  logic [2:0]  ctl_mode = 3'h0;
  int          fails = 0, n_checks = 0;

  erf_rx_fifo dut (.*);
  erf_bulk_model rd (.*);
  always #4 ref_clk = ~ref_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task stop_test;
    $display("comparisons %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge ref_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_ack_o !== 1'h1 && k < 50);
    if (k >= 50) fails++;
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask

  // extra words beyond the stated length push the frame into overflow
  task frame(input int len, input logic e, input logic f, input logic [1:0] p, input int extra);
    logic [31:0] d;
    logic        kept;
    int          n;
    n = (len + 5) / 4 + extra;
    kept = (extra == 0) && (!(e || f) || ctl_mode[0]);
    d = $urandom;
    @(posedge ref_clk);
    flt_sof <= 1'h1;
    flt_frame_length <= ctl_mode[1] ? 14'(len + 4) : 14'(len);
    {flt_ip_raw_l3_checksum_field_err, flt_l4_raw_l3_checksum_field_err, flt_ipv6} <= d[2:0];
    {flt_exact_pass, flt_bcast} <= d[4:3];
    flt_proto <= p;
    flt_rx_err <= e;
    flt_filtered <= f;
    flt_raw_raw_l3_checksum_field <= d[31:16];
    flt_vlan_tag <= d[20:5];
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      if (i == 0 && kept) begin
        exp_q.push_back({flt_ip_raw_l3_checksum_field_err, flt_l4_raw_l3_checksum_field_err, flt_ipv6, flt_proto, flt_exact_pass,
                         flt_bcast, 11'h000, 14'(len)});
        exp_q.push_back({ctl_mode[2] ? flt_raw_raw_l3_checksum_field : 16'h0000, flt_vlan_tag});
      end
      d = $urandom;
      if (kept) exp_q.push_back(d);
      flt_sof <= 1'h0;
      flt_valid <= 1'h1;
      flt_data <= d;
      flt_eof <= (i == n - 1);
    end
    @(posedge ref_clk);
    flt_valid <= 1'h0;
    flt_eof <= 1'h0;
    repeat (3) @(posedge ref_clk);
  endtask

  task drain;
    for (int k = 0; k < 20000 && (exp_q.size() > 0 || rd.got.size() > 0); k++)
      @(posedge ref_clk);
    check({31'h0, exp_q.size() == 0}, 32'h1);
    repeat (6) @(posedge ref_clk);
    check({31'h0, bulk_frame_avail}, 32'h0);
  endtask

  always @(posedge ref_clk)
    if (rd.got.size() > 0 && exp_q.size() == 0) fails++;
    else if (rd.got.size() > 0) check(rd.got.pop_front(), exp_q.pop_front());

  initial begin
    #480000;
    fails++;
    stop_test();
  end

  initial begin
    rv = $urandom(47);
    repeat (10) @(posedge ref_clk);
    rst <= 1'h0;
    for (int a = 0; a < 16; a += 4) begin
      wb(1'h0, a[7:0], 32'h0, rv);
      check(rv, 32'h0);
    end
    for (int m = 0; m < 8; m++)
      for (int p = 0; p < 4; p++) begin
        ctl_mode = m[2:0];
        wb(1'h1, `ERF_CTL_ADDR, {29'h0, ctl_mode}, rv);
        frame(10 + $urandom % 64, 1'h0, 1'h0, p[1:0], 0);
        frame(10 + $urandom % 64, 1'h1, 1'h0, p[1:0], 0);
        frame(10 + $urandom % 64, 1'h0, 1'h1, p[1:0], 0);
      end
    drain();
    rd_rewind_req <= 1'h1;
    frame(40, 1'h0, 1'h0, 2'h1, 0);
    drain();
    check({31'h0, rd.used_rw}, 32'h1);
    rd_rewind_req <= 1'h0;
    ctl_mode = 3'h0;
    wb(1'h1, `ERF_CTL_ADDR, 32'h0, rv);
    rd_hold <= 1'h1;
    frame(20, 1'h0, 1'h0, 2'h2, 3100);
    frame(20, 1'h0, 1'h0, 2'h3, 0);
    repeat (4) @(posedge ref_clk);
    check({31'h0, overflow_irq}, 32'h1);
    check({31'h0, bulk_frame_avail}, 32'h1);
    check({20'h0, bulk_used_words}, 32'h7);
    wb(1'h0, `ERF_OVF_CNT_ADDR, 32'h0, rv);
    check(rv, 32'h1);
    wb(1'h0, `ERF_CTL_ADDR, 32'h0, rv);
    check(rv, 32'h0007_0008);
    wb(1'h0, `ERF_FRAMES_ADDR, 32'h0, rv);
    check(rv, 32'h1);
    wb(1'h1, `ERF_CTL_ADDR, 32'h8, rv);
    wb(1'h0, `ERF_CTL_ADDR, 32'h0, rv);
    check(rv, 32'h0007_0000);
    check({31'h0, overflow_irq}, 32'h0);
    rd_hold <= 1'h0;
    drain();
    wb(1'h0, `ERF_FRAMES_ADDR, 32'h0, rv);
    check(rv, 32'h0);
    stop_test();
  end
endmodule
